// file: rtl/psr_link_if.sv
interface psr_link_if;
    psr_pkg::psr_code_t snap;
    psr_pkg::psr_mode_t mode;
    modport core  (output snap, output mode);
    modport shift (input snap, input mode);
endinterface : psr_link_if

// file: rtl/psr_params.svh
// What this block does
// - refresh output register with a corrected 12-bit-resolution code every 500 us.
// - refresh timer runs freely, never waits for or follows serial traffic.
// - master owns clock, MOSI and select; device is slave driving MISO only.
// - all four polarity/phase modes work; default polarity 0, phase 0.
// - falling edge of slave-select starts a new transfer.
// - first byte is filler with upper bits all ones; master discards it.
// - bytes two and three: one don't-care bit, then P14..P0, MSB first.
// - unidirectional code: 3277 at zero, 29491 at full scale, span 26214.
// - bidirectional code: 16384 at zero, 29491 at maximum, 3277 at minimum.
// - code does not scale with supply; same encoding for 5 V and 3 V parts.
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

`define PSR_CLK_HZ       25000000
`define PSR_PERIOD_US    500
`define PSR_PERIOD_CYC   ((`PSR_PERIOD_US * (`PSR_CLK_HZ / 1000000)))
`define PSR_TMR_W        14

`define PSR_ZERO_UNI     15'h0CCD
`define PSR_ZERO_BI      15'h4000
`define PSR_FULL         15'h7333
`define PSR_SPAN         15'h6666
`define PSR_K_UNI        15'h666C
`define PSR_K_BI         15'h6673
`define PSR_ROUND        27'h0000800
`define PSR_SHIFT        12
`define PSR_MAG_MAX      12'h7FF
`define PSR_MAG_MIN_NEG  12'h800

`define PSR_FILLER       8'hFF
`define PSR_DONT_CARE    1'b0
`define PSR_FRAME_BITS   5'h18
`define PSR_IDLE_BIT     1'b1

`define PSR_PIN_SS       0
`define PSR_PIN_CPOL     1
`define PSR_PIN_CPHA     2
`define PSR_PIN_BIDIR    3
`define PSR_PIN_RST      4'h1

`endif

// file: rtl/psr_pkg.sv
package psr_pkg;
    typedef logic [14:0] psr_code_t;
    typedef struct packed {
        logic cpol;
        logic cpha;
    } psr_mode_t;
    typedef enum logic {PSR_SEL_IDLE, PSR_SEL_ACTIVE} psr_sel_t;
endpackage : psr_pkg

// file: rtl/psr_readout.sv
`include "psr_params.svh"

module psr_readout #(
    parameter int unsigned PERIOD_CYCLES = `PSR_PERIOD_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        spi_sck_i,
    input  wire logic        spi_ss_n_i,
    input  wire logic        cpol_i,
    input  wire logic        cpha_i,
    input  wire logic        bidir_i,
    input  wire logic [11:0] sample_i,
    output logic             spi_miso_o,
    output logic             spi_miso_oe_o,
    output logic [14:0]      code_o,
    output logic             refresh_o,
    output logic [15:0]      frames_o
);
    // ------------------------------------------------------------------
    // pin synchronisers: three stages, a change counts when 2 and 3 agree
    // ------------------------------------------------------------------
    // the straps and select arrive from the master's side with no relation
    // to clk_i; the first stage may go metastable, so only stages two and
    // three vote, and a lone disagreement leaves the filtered value alone
    // cost: about four clk_i cycles of lag on select and mode
    logic [3:0] pins;
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] s3_ff;
    logic [3:0] pin_ff;
    logic [3:0] nxt_pin;

    assign pins = {bidir_i, cpha_i, cpol_i, spi_ss_n_i};

    // reset value keeps select high, so no frame starts out of reset
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            always_comb begin
                nxt_pin[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : pin_ff[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_ff  <= `PSR_PIN_RST;
            s2_ff  <= `PSR_PIN_RST;
            s3_ff  <= `PSR_PIN_RST;
            pin_ff <= `PSR_PIN_RST;
        end else begin
            s1_ff  <= pins;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // ------------------------------------------------------------------
    // cyclic refresh timer, free running whatever the bus does
    // ------------------------------------------------------------------
    // the timer only counts clk_i; select, clock and mode never reach it,
    // so a reader can neither stall nor speed up a refresh
    // width fits the default period; a longer period needs a wider timer
    logic [`PSR_TMR_W-1:0] tmr_ff;
    logic [`PSR_TMR_W-1:0] nxt_tmr;
    logic                  tick;

    always_comb begin
        tick    = (tmr_ff == `PSR_TMR_W'(PERIOD_CYCLES - 1));
        nxt_tmr = tick ? '0 : tmr_ff + `PSR_TMR_W'(1);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tmr_ff <= '0;
        end else begin
            tmr_ff <= nxt_tmr;
        end
    end

    // ------------------------------------------------------------------
    // conversion of the 12-bit corrected sample to the count encoding
    // ------------------------------------------------------------------
    // scale factors carry 12 fraction bits with rounding, so the ends
    // land exactly on the documented counts without a divider
    // bidirectional: the sample is two's complement, so its magnitude is
    // scaled and then added to or taken from the mid-scale count
    // limitation: the mapping is linear only; any curve correction must
    // already be in the sample
    psr_pkg::psr_code_t conv;
    logic [11:0]        mag;
    logic [26:0]        prod;
    logic [14:0]        step;

    always_comb begin
        mag  = sample_i;
        prod = '0;
        step = '0;
        conv = `PSR_ZERO_UNI;
        if (pin_ff[`PSR_PIN_BIDIR]) begin
            // signed sample; the most negative code is clamped for symmetry
            mag = sample_i[11] ? (12'h000 - sample_i) : sample_i;
            if (mag > `PSR_MAG_MAX) begin
                mag = `PSR_MAG_MAX;
            end
            prod = 27'(mag) * 27'(`PSR_K_BI);
            step = 15'((prod + `PSR_ROUND) >> `PSR_SHIFT);
            conv = sample_i[11] ? (`PSR_ZERO_BI - step) : (`PSR_ZERO_BI + step);
        end else begin
            prod = 27'(sample_i) * 27'(`PSR_K_UNI);
            step = 15'((prod + `PSR_ROUND) >> `PSR_SHIFT);
            conv = `PSR_ZERO_UNI + step;
        end
    end

    // ------------------------------------------------------------------
    // output register, select state, snapshot and mode hold
    // ------------------------------------------------------------------
    // out_ff is the live output register; snap_ff is the copy a frame reads
    psr_pkg::psr_code_t out_ff;
    psr_pkg::psr_code_t nxt_out;
    psr_pkg::psr_code_t snap_ff;
    psr_pkg::psr_code_t nxt_snap;
    psr_pkg::psr_mode_t mode_ff;
    psr_pkg::psr_mode_t nxt_mode;
    psr_pkg::psr_sel_t  sel_ff;
    psr_pkg::psr_sel_t  nxt_sel;
    logic               nxt_refresh;
    logic               nxt_oe;
    logic [15:0]        frames_ff;
    logic [15:0]        nxt_frames;

    // refresh_o and the new code appear on the same edge, so a watcher
    // can take code_o in the cycle refresh_o is high
    always_comb begin
        nxt_out     = out_ff;
        nxt_refresh = 1'b0;
        if (tick) begin
            // no supply input reaches the code: encoding is fixed
            nxt_out     = conv;
            nxt_refresh = 1'b1;
        end
    end

    // the snapshot is copied every cycle while idle and then frozen; that
    // freeze lands a few cycles after select falls, long before the first
    // payload bit, so a mid-frame refresh cannot split bytes two and three
    always_comb begin
        nxt_sel    = sel_ff;
        nxt_snap   = snap_ff;
        nxt_mode   = mode_ff;
        nxt_frames = frames_ff;
        unique case (sel_ff)
            psr_pkg::PSR_SEL_IDLE: begin
                // snapshot and mode follow freely only while deselected
                nxt_snap      = out_ff;
                nxt_mode.cpol = pin_ff[`PSR_PIN_CPOL];
                nxt_mode.cpha = pin_ff[`PSR_PIN_CPHA];
                if (!pin_ff[`PSR_PIN_SS]) begin
                    nxt_sel = psr_pkg::PSR_SEL_ACTIVE;
                end
            end
            psr_pkg::PSR_SEL_ACTIVE: begin
                // frozen for the whole frame, well before byte two is shifted
                if (pin_ff[`PSR_PIN_SS]) begin
                    nxt_sel    = psr_pkg::PSR_SEL_IDLE;
                    nxt_frames = frames_ff + 16'h0001;
                end
            end
        endcase
        // enable follows the next state so it rises with sel_ff, not after
        nxt_oe = (nxt_sel == psr_pkg::PSR_SEL_ACTIVE);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_ff        <= `PSR_ZERO_UNI;
            snap_ff       <= `PSR_ZERO_UNI;
            mode_ff       <= '0;
            sel_ff        <= psr_pkg::PSR_SEL_IDLE;
            frames_ff     <= 16'h0000;
            refresh_o     <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else begin
            out_ff        <= nxt_out;
            snap_ff       <= nxt_snap;
            mode_ff       <= nxt_mode;
            sel_ff        <= nxt_sel;
            frames_ff     <= nxt_frames;
            refresh_o     <= nxt_refresh;
            spi_miso_oe_o <= nxt_oe;
        end
    end

    // frames_o counts select-high events seen by the core; a select
    // pulse shorter than the filter may be missed by design
    assign code_o   = out_ff;
    assign frames_o = frames_ff;

    // ------------------------------------------------------------------
    // link side: the snapshot and mode are static while select is low
    // ------------------------------------------------------------------
    // snap and mode cross into the sck domain without a handshake: they
    // are held still for the whole frame, which is the handshake
    // limitation: the master must leave about 200 ns after select falls
    // before its first clock edge, and must not change the mode straps
    // while selected; a clock edge inside that gap may shift stale data
    // a mid-frame reset clears the shifter too, so the master sees ones
    psr_link_if link ();

    assign link.snap = snap_ff;
    assign link.mode = mode_ff;

    // the shifter runs on sck alone; clk_i only feeds it static words
    psr_spi_shifter u_shift (
        .spi_sck_i  (spi_sck_i),
        .spi_ss_n_i (spi_ss_n_i),
        .reset_i    (reset_i),
        .link       (link.shift),
        .miso_o     (spi_miso_o)
    );
endmodule : psr_readout

// file: rtl/psr_spi_shifter.sv
`include "psr_params.svh"

module psr_spi_shifter (
    input  wire logic   spi_sck_i,
    input  wire logic   spi_ss_n_i,
    input  wire logic   reset_i,
    psr_link_if.shift   link,
    output logic        miso_o
);
    logic        launch_clk;
    logic        clr;
    logic [23:0] frame;
    logic [4:0]  cnt_ff;
    logic [4:0]  nxt_cnt;
    logic [4:0]  idx;
    logic        nxt_miso;

    // launch edge is the trailing edge for phase 0, leading edge for phase 1
    assign launch_clk = ~(spi_sck_i ^ link.mode.cpol ^ link.mode.cpha);
    // deselect holds the shifter cleared, so stray clocks do nothing
    assign clr        = spi_ss_n_i | reset_i;
    assign frame      = {`PSR_FILLER, `PSR_DONT_CARE, link.snap};

    always_comb begin
        // phase 0 already shows bit 0 at select, so each launch moves one ahead
        idx      = link.mode.cpha ? cnt_ff : cnt_ff + 5'h01;
        nxt_miso = `PSR_IDLE_BIT;
        if (idx < `PSR_FRAME_BITS) begin
            nxt_miso = frame[5'h17 - idx];
        end
        nxt_cnt = (cnt_ff == `PSR_FRAME_BITS) ? cnt_ff : cnt_ff + 5'h01;
    end

    // select falling releases the clear: that is the start of a transfer
    always_ff @(posedge launch_clk or posedge clr) begin
        if (clr) begin
            cnt_ff <= 5'h00;
            miso_o <= `PSR_IDLE_BIT;
        end else begin
            cnt_ff <= nxt_cnt;
            miso_o <= nxt_miso;
        end
    end
endmodule : psr_spi_shifter

// file: tb/psr_readout_assertions.sv
module psr_readout_chk #(
    parameter int unsigned PERIOD_CYCLES = 12500
) (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        spi_sck_i,
    input wire logic        spi_ss_n_i,
    input wire logic        cpol_i,
    input wire logic        cpha_i,
    input wire logic        bidir_i,
    input wire logic [11:0] sample_i,
    input wire logic        spi_miso_o,
    input wire logic        spi_miso_oe_o,
    input wire logic [14:0] code_o,
    input wire logic        refresh_o,
    input wire logic [15:0] frames_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [15:0] cnt_ff, nxt_cnt;
    logic        seen_ff, nxt_seen;
    always_comb begin
        nxt_cnt = refresh_o ? 16'h0000 : cnt_ff + 16'h0001;
        nxt_seen = seen_ff | refresh_o;
    end
    // first interval skipped: its start is tied to reset release, not a tick
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_ff <= 16'h0000;
            seen_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            seen_ff <= nxt_seen;
        end
    end
    property p_period; refresh_o && seen_ff |-> cnt_ff == 16'(PERIOD_CYCLES - 1); endproperty
    a_period: assert property (p_period) else $error("refresh spacing wrong");
    property p_bound; seen_ff |-> cnt_ff < 16'(PERIOD_CYCLES); endproperty
    a_bound: assert property (p_bound) else $error("refresh overdue");
    property p_hold; $changed(code_o) |-> refresh_o; endproperty
    a_hold: assert property (p_hold) else $error("code moved without refresh");
    property p_range; code_o >= 15'h0CCD && code_o <= 15'h7333; endproperty
    a_range: assert property (p_range) else $error("code out of span");
    property p_idle; spi_ss_n_i |-> spi_miso_o; endproperty
    a_idle: assert property (p_idle) else $error("miso low while idle");
    property p_oe_on; !spi_ss_n_i [*6] |-> spi_miso_oe_o; endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven");
    property p_oe_off; spi_ss_n_i [*6] |-> !spi_miso_oe_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven while idle");
    property p_first; !spi_ss_n_i && !spi_miso_oe_o |-> spi_miso_o; endproperty
    a_first: assert property (p_first) else $error("first bit not one");
endmodule : psr_readout_chk

bind psr_readout psr_readout_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) i_chk (
    .clk_i(clk_i), .reset_i(reset_i), .spi_sck_i(spi_sck_i), .spi_ss_n_i(spi_ss_n_i),
    .cpol_i(cpol_i), .cpha_i(cpha_i), .bidir_i(bidir_i), .sample_i(sample_i),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .code_o(code_o),
    .refresh_o(refresh_o), .frames_o(frames_o));

// file: tb/psr_spi_master.sv
module psr_spi_master (
    output logic     sck_o,
    output logic     ss_n_o,
    input wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sck_o = 1'b0;
        ss_n_o = 1'b1;
    end
    task automatic park(input logic cpol);
        sck_o = cpol;
    endtask : park
    // no mosi pin on the device, so the all-ones stream is implied
    task automatic xfer(input logic cpol, input logic cpha, output logic [23:0] w);
        #7 ss_n_o = 1'b0;
        #300;
        for (int i = 0; i < 24; i++) begin
            if (!cpha) w = {w[22:0], miso_i};
            sck_o = ~cpol;
            // 48 ns period keeps runs short; far above the real pin limit
            #24;
            if (cpha) w = {w[22:0], miso_i};
            sck_o = cpol;
            #24;
        end
        ss_n_o = 1'b1;
    endtask : xfer
endmodule : psr_spi_master

// file: tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, reset_i = 1'b1, cpol_i = 1'b0, cpha_i = 1'b0, bidir_i = 1'b0;
    logic [11:0] sample_i = 12'h000;
    logic        sck, ss_n, miso, miso_oe, refresh;
    logic [14:0] code, cur;
    logic [15:0] frames, fr0;
    logic [23:0] w;
    logic [14:0] q[$];
    logic [12:0] tbl[6] = '{13'h0000, 13'h0FFF, 13'h1000, 13'h17FF, 13'h1801, 13'h1800};
    int          fails = 0, n_checks = 0, seed = 8031;
    // undriven line shows the inverse so a stale value cannot pass
    wire         miso_w = miso_oe ? miso : ~miso;

    psr_readout #(.PERIOD_CYCLES(50)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .spi_sck_i(sck), .spi_ss_n_i(ss_n), .cpol_i(cpol_i), .cpha_i(cpha_i),
        .bidir_i(bidir_i), .sample_i(sample_i), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .code_o(code), .refresh_o(refresh), .frames_o(frames));
    psr_spi_master i_mst (.sck_o(sck), .ss_n_o(ss_n), .miso_i(miso_w));

    always #20 clk_i = ~clk_i;

    function automatic logic [14:0] exp_code(input logic b, input logic [11:0] s);
        int m;
        m = $signed(s);
        if (!b) return 15'(3277 + (int'(s) * 26220 + 2048) / 4096);
        if (m < -2047) m = -2047;
        if (m < 0) return 15'(16384 - (-m * 26227 + 2048) / 4096);
        return 15'(16384 + (m * 26227 + 2048) / 4096);
    endfunction : exp_code

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    always @(negedge clk_i) begin
        if (refresh === 1'b1 && q.size() > 0) check(24'(code), 24'(q.pop_front()));
    end

    initial begin
        repeat (3) @(negedge clk_i);
        reset_i = 1'b0;
        check(24'(code), 24'h000CCD);
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_i);
            {bidir_i, sample_i} = i < 6 ? tbl[i] : 13'($random(seed));
            cur = exp_code(bidir_i, sample_i);
            q.push_back(cur);
            @(negedge clk_i iff refresh === 1'b1);
            // start late so the next refresh lands inside the frame
            repeat (20) @(negedge clk_i);
            i_mst.park(i[1]);
            {cpol_i, cpha_i} = 2'(i);
            repeat (6) @(negedge clk_i);
            fr0 = frames;
            // new sample after the freeze: the refresh inside the frame must not reach it
            fork
                i_mst.xfer(cpol_i, cpha_i, w);
                begin
                    repeat (10) @(negedge clk_i);
                    sample_i = ~sample_i;
                end
            join
            check(24'(w[23:16]), 24'h0000FF);
            check(24'(w[15:0]), {9'h000, cur});
            repeat (8) @(negedge clk_i);
            check(24'(frames), 24'(fr0 + 16'h0001));
        end
        test_done();
    end

    initial begin
        #100000;
        fails++;
        test_done();
    end
endmodule : testbench
